// [src/pbs_pkg.sv]
/*
 pbs_pkg: constants and carrier types for the pushbutton power sequencer.
 Assumes a single 50 MHz core clock; all durations are derived from it.
*/
`default_nettype none
package pbs_pkg;
    localparam int CLK_HZ          = 50_000_000;
    localparam int DEBOUNCE_MS     = 32;
    localparam int BLANK_MS        = 512;
    localparam int SHUTDOWN_MS     = 1024;
    localparam int LOCKOUT_MS      = 256;
    localparam int KILL_FILTER_US  = 1;
    localparam int CYC_PER_MS      = CLK_HZ / 1000;
    localparam int CYC_PER_US      = CLK_HZ / 1_000_000;
    // kill filter is far below the 30 us recognise/release bounds
    localparam int KILL_FILTER_CYC = KILL_FILTER_US * CYC_PER_US;
    localparam int EXT_W           = 16;
    localparam int MS_W            = 24;
    localparam int MS_CNT_W        = 17;
    localparam int KF_W            = 8;

    // main sequencer states
    typedef enum logic [2:0] {
        PBS_IDLE,
        PBS_ON_DEB,
        PBS_BLANK,
        PBS_REL_DEB,
        PBS_RUN,
        PBS_OFF_DEB,
        PBS_SHUTDOWN,
        PBS_LOCKOUT
    } pbs_state_type;

    // extension settings, in whole milliseconds
    typedef struct packed {
        logic [EXT_W-1:0] turn_on_extend;
        logic [EXT_W-1:0] turn_off_extend;
    } pbs_cfg_type;

    // open-drain enable pin: drive value plus enable
    typedef struct packed {
        logic en_out;
        logic en_oe;
    } pbs_pin_type;
endpackage : pbs_pkg
`default_nettype wire

// [src/pbs_sequencer.sv]
/*
 pbs_sequencer: pushbutton on/off power sequencer with microprocessor handshake.
 Assumes button_n and kill_n may be asynchronous; each passes a two-flop synchronizer; the board resolves the
 enable pin from en_pin.en_oe and its pull-up when ACTIVE_LOW_EN makes it open-drain, else from en_pin.en_out.
*/
`default_nettype none
module pbs_sequencer #(
    parameter bit        ACTIVE_LOW_EN = 1'b0,
    parameter int        CYC_MS        = pbs_pkg::CYC_PER_MS
) (
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    // pushbutton and processor handshake
    input  wire logic                 button_n,
    input  wire logic                 kill_n,
    input  wire pbs_pkg::pbs_cfg_type cfg,
    output logic                      shutdown_req_n,
    // open-drain enable pin
    output pbs_pkg::pbs_pin_type      en_pin
);
    import pbs_pkg::*;

    logic [1:0]          btn_sync;
    logic [1:0]          kill_sync;
    logic                btn_prev;
    logic [MS_W-1:0]     tick_cnt;
    logic                ms_tick;
    logic [KF_W-1:0]     kf_cnt;
    logic                kill_low;
    pbs_state_type       state;
    logic [MS_CNT_W-1:0] ms_cnt;
    logic                power_on;
    logic                req;
    logic                next_btn_prev;
    logic [MS_W-1:0]     next_tick_cnt;
    logic                next_ms_tick;
    logic [KF_W-1:0]     next_kf_cnt;
    logic                next_kill_low;
    pbs_state_type       next_state;
    logic [MS_CNT_W-1:0] next_ms_cnt;
    logic                next_power_on;
    logic                next_req;
    logic                btn;
    logic [MS_CNT_W-1:0] on_target;
    logic [MS_CNT_W-1:0] off_target;

    // second sync stage only; first stage feeds nothing else
    assign btn = btn_sync[1];
    assign on_target  = MS_CNT_W'(DEBOUNCE_MS) + MS_CNT_W'(cfg.turn_on_extend);
    assign off_target = MS_CNT_W'(DEBOUNCE_MS) + MS_CNT_W'(cfg.turn_off_extend);

    // millisecond enable and short kill filter
    always_comb begin
        next_btn_prev = btn;
        next_ms_tick  = 1'b0;
        next_tick_cnt = tick_cnt + MS_W'(1);
        if (tick_cnt == MS_W'(CYC_MS - 1)) begin
            next_tick_cnt = '0;
            next_ms_tick  = 1'b1;
        end
        // kill needs a short steady low so glitches do not cut power
        next_kf_cnt   = '0;
        next_kill_low = 1'b0;
        if (!kill_sync[1]) begin
            next_kf_cnt   = kf_cnt;
            next_kill_low = kill_low;
            if (kf_cnt == KF_W'(KILL_FILTER_CYC)) begin
                next_kill_low = 1'b1;
            end else begin
                next_kf_cnt = kf_cnt + KF_W'(1);
            end
        end
    end

    // sequencer next state
    always_comb begin
        next_state    = state;
        next_ms_cnt   = ms_cnt;
        next_power_on = power_on;
        next_req      = req;
        if (ms_tick && ms_cnt != '1) begin
            next_ms_cnt = ms_cnt + MS_CNT_W'(1);
        end
        case (state)
            PBS_IDLE: begin
                next_ms_cnt = '0;
                if (btn_prev && !btn) begin
                    next_state = PBS_ON_DEB;
                end
            end
            PBS_ON_DEB: begin
                if (btn) begin
                    next_state = PBS_IDLE;
                end else if (ms_cnt >= on_target) begin
                    next_state    = PBS_BLANK;
                    next_power_on = 1'b1;
                    next_ms_cnt   = '0;
                end
            end
            PBS_BLANK: begin
                // inputs ignored until blanking expires
                if (ms_cnt >= MS_CNT_W'(BLANK_MS)) begin
                    next_ms_cnt = '0;
                    if (kill_low) begin
                        next_state    = PBS_LOCKOUT;
                        next_power_on = 1'b0;
                    end else begin
                        next_state = PBS_REL_DEB;
                    end
                end
            end
            PBS_REL_DEB: begin
                if (kill_low) begin
                    next_state    = PBS_LOCKOUT;
                    next_power_on = 1'b0;
                    next_ms_cnt   = '0;
                end else if (!btn) begin
                    next_ms_cnt = '0;
                end else if (ms_cnt >= MS_CNT_W'(DEBOUNCE_MS)) begin
                    next_state = PBS_RUN;
                end
            end
            PBS_RUN: begin
                next_ms_cnt = '0;
                if (kill_low) begin
                    next_state    = PBS_LOCKOUT;
                    next_power_on = 1'b0;
                end else if (!btn) begin
                    next_state = PBS_OFF_DEB;
                end
            end
            PBS_OFF_DEB: begin
                if (kill_low) begin
                    next_state    = PBS_LOCKOUT;
                    next_power_on = 1'b0;
                    next_ms_cnt   = '0;
                end else if (btn) begin
                    next_state = PBS_RUN;
                end else if (ms_cnt >= off_target) begin
                    next_state  = PBS_SHUTDOWN;
                    next_req    = 1'b1;
                    next_ms_cnt = '0;
                end
            end
            PBS_SHUTDOWN: begin
                if (kill_low || ms_cnt >= MS_CNT_W'(SHUTDOWN_MS)) begin
                    next_state    = PBS_LOCKOUT;
                    next_power_on = 1'b0;
                    next_req      = 1'b0;
                    next_ms_cnt   = '0;
                end
            end
            PBS_LOCKOUT: begin
                // button ignored; then wait for a released button
                if (ms_cnt >= MS_CNT_W'(LOCKOUT_MS + DEBOUNCE_MS)) begin
                    next_state = PBS_IDLE;
                end else if (ms_cnt >= MS_CNT_W'(LOCKOUT_MS) && !btn) begin
                    next_ms_cnt = MS_CNT_W'(LOCKOUT_MS);
                end
            end
            default: begin
                next_state    = PBS_IDLE;
                next_power_on = 1'b0;
                next_req      = 1'b0;
            end
        endcase
    end

    // registers; outputs come straight from flops
    always_ff @(posedge core_clk) begin
        if (rst) begin
            btn_sync       <= 2'h3;
            kill_sync      <= 2'h3;
            btn_prev       <= 1'b1;
            tick_cnt       <= '0;
            ms_tick        <= 1'b0;
            kf_cnt         <= '0;
            kill_low       <= 1'b0;
            state          <= PBS_IDLE;
            ms_cnt         <= '0;
            power_on       <= 1'b0;
            req            <= 1'b0;
            shutdown_req_n <= 1'b1;
            en_pin         <= {1'b0, !ACTIVE_LOW_EN};
        end else begin
            btn_sync       <= {btn_sync[0], button_n};
            kill_sync      <= {kill_sync[0], kill_n};
            btn_prev       <= next_btn_prev;
            tick_cnt       <= next_tick_cnt;
            ms_tick        <= next_ms_tick;
            kf_cnt         <= next_kf_cnt;
            kill_low       <= next_kill_low;
            state          <= next_state;
            ms_cnt         <= next_ms_cnt;
            power_on       <= next_power_on;
            req            <= next_req;
            shutdown_req_n <= !next_req;
            // variant 1 drives high/low; variant 2 sinks on, floats off
            en_pin.en_out  <= ACTIVE_LOW_EN ? 1'b0 : next_power_on;
            en_pin.en_oe   <= ACTIVE_LOW_EN ? next_power_on : 1'b1;
        end
    end
endmodule : pbs_sequencer
`default_nettype wire

// [tb/pbs_assertions.sv]
/* pbs_assertions: port timing checks for pbs_sequencer.
 Assumes the bind below; times scale with CYC_MS except the 1500-cycle kill bound. */
`default_nettype none
module pbs_assertions #(
    parameter bit ACTIVE_LOW_EN = 1'b0,
    parameter int CYC_MS        = pbs_pkg::CYC_PER_MS
) (
    // watched ports
    input wire logic                 core_clk,
    input wire logic                 rst,
    input wire logic                 button_n,
    input wire logic                 kill_n,
    input wire pbs_pkg::pbs_cfg_type cfg,
    input wire logic                 shutdown_req_n,
    input wire pbs_pkg::pbs_pin_type en_pin
);
    import pbs_pkg::*;
    localparam int BLK = BLANK_MS * CYC_MS;
    logic on;
    int   on_cnt, off_cnt, low_cnt, klow, req_cnt;
    assign on = ACTIVE_LOW_EN ? en_pin.en_oe : en_pin.en_out;
    // run lengths; kill counted only past blanking, as it is ignored before
    always_ff @(posedge core_clk) begin
        on_cnt  <= (rst || !on) ? 0 : on_cnt + 1;
        off_cnt <= rst ? 32'h00FF_FFFF : (on ? 0 : off_cnt + 1);
        low_cnt <= button_n ? 0 : low_cnt + 1;
        klow    <= (on && !kill_n && on_cnt > BLK + CYC_MS) ? klow + 1 : 0;
        req_cnt <= shutdown_req_n ? 0 : req_cnt + 1;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    pin_mode_a: assert property (ACTIVE_LOW_EN ? !en_pin.en_out : en_pin.en_oe)
        else $error("bad pin drive");
    on_debounce_a: assert property ($rose(on)
        |-> low_cnt >= (DEBOUNCE_MS + cfg.turn_on_extend - 1) * CYC_MS) else $error("early on");
    off_debounce_a: assert property ($fell(shutdown_req_n)
        |-> low_cnt >= (DEBOUNCE_MS + cfg.turn_off_extend - 1) * CYC_MS) else $error("early req");
    blank_hold_a: assert property ($fell(on) |-> on_cnt >= BLK - CYC_MS)
        else $error("off in blank");
    kill_release_a: assert property (klow < 1500)
        else $error("kill slow");
    req_clear_a: assert property (!on |-> shutdown_req_n)
        else $error("req while off");
    req_timeout_a: assert property (req_cnt <= (SHUTDOWN_MS + 1) * CYC_MS + 8)
        else $error("no timeout");
    lockout_a: assert property ($rose(on) |-> off_cnt >= (LOCKOUT_MS - 1) * CYC_MS)
        else $error("lockout short");
endmodule : pbs_assertions
bind pbs_sequencer pbs_assertions #(.ACTIVE_LOW_EN(ACTIVE_LOW_EN), .CYC_MS(CYC_MS))
    i_pbs_assertions (.core_clk(core_clk), .rst(rst), .button_n(button_n), .kill_n(kill_n),
    .cfg(cfg), .shutdown_req_n(shutdown_req_n), .en_pin(en_pin));
`default_nettype wire

// [tb/pbs_proc_model.sv]
/* pbs_proc_model: processor side of the kill handshake.
 Assumes the bench clock; acts just after falling edges. */
`default_nettype none
module pbs_proc_model (
    // bench control
    input  wire logic       core_clk,
    input  wire logic [1:0] mode,
    input  wire logic       kill_req,
    // sequencer side
    input  wire logic       powered,
    input  wire logic       shutdown_req_n,
    output logic            kill_n
);
    timeunit 1ns;
    timeprecision 1ns;
    int boot = 0;
    int ack = 0;
    // unpowered cpu holds kill low; mode 1 never boots, mode 2 ignores requests
    always @(negedge core_clk) begin
        boot <= powered ? boot + 1 : 0;
        ack  <= shutdown_req_n ? 0 : ack + 1;
        if (!powered || kill_req || (mode == 2'h0 && ack > 200)) kill_n <= 1'b0;
        else if (boot == 100 && mode != 2'h1) kill_n <= 1'b1;
    end
endmodule : pbs_proc_model
`default_nettype wire

// [tb/testbench.sv]
/* testbench: scenario tasks for pbs_sequencer.
 Assumes pbs_proc_model on kill and a 10-cycle millisecond. */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import pbs_pkg::*;
    localparam int CM   = 10;
    localparam int IDLE = (LOCKOUT_MS + DEBOUNCE_MS + 4) * CM;
    localparam int RUNW = (BLANK_MS + DEBOUNCE_MS + 4) * CM;
    logic        core_clk = 1'b0;
    logic        rst      = 1'b1;
    logic        button_n = 1'b1;
    logic        kill_req = 1'b0;
    logic [1:0]  mode     = 2'h0;
    pbs_cfg_type cfg      = '0;
    logic        kill_n, shutdown_req_n, shutdown_lo_n;
    pbs_pin_type en_pin, en_pin_lo;
    int          fails, tests_run, n;
    pbs_sequencer #(.ACTIVE_LOW_EN(1'b0), .CYC_MS(CM)) i_pbs_sequencer (.core_clk(core_clk),
        .rst(rst), .button_n(button_n), .kill_n(kill_n), .cfg(cfg),
        .shutdown_req_n(shutdown_req_n), .en_pin(en_pin));
    pbs_proc_model i_pbs_proc_model (.core_clk(core_clk), .mode(mode), .kill_req(kill_req),
        .powered(en_pin.en_out), .shutdown_req_n(shutdown_req_n), .kill_n(kill_n));
    // variant two on the same inputs; its pin must mirror variant one
    pbs_sequencer #(.ACTIVE_LOW_EN(1'b1), .CYC_MS(CM)) i_pbs_sequencer_lo (.core_clk(core_clk),
        .rst(rst), .button_n(button_n), .kill_n(kill_n), .cfg(cfg),
        .shutdown_req_n(shutdown_lo_n), .en_pin(en_pin_lo));
    // 50 MHz clock
    initial forever #10 core_clk = ~core_clk;
    task automatic chk(input string what, input logic ok);
        tests_run++;
        if (ok !== 1'b1) begin
            fails++;
            $display("[FAIL] %s expected 1 seen %b", what, ok);
        end
    endtask : chk
    task automatic wait_en(input logic val, input int max);
        for (n = 0; n < max && en_pin.en_out !== val; n++) @(negedge core_clk);
    endtask : wait_en
    task automatic power_on();
        button_n = 1'b0;
        wait_en(1'b1, 400);
        chk("power on", n < 400);
        button_n = 1'b1;
    endtask : power_on
    // variant one always drives; variant two sinks when on, floats when off
    task automatic chk_pins();
        logic ok;
        ok = en_pin.en_oe === 1'b1 && en_pin_lo.en_out === 1'b0;
        ok = ok && en_pin_lo.en_oe === en_pin.en_out && shutdown_lo_n === shutdown_req_n;
        chk("pin drive", ok);
    endtask : chk_pins
    task automatic t_power_on();
        chk("reset idle", en_pin.en_out === 1'b0 && shutdown_req_n === 1'b1);
        cfg.turn_on_extend = 16'h0002;
        button_n = 1'b0;
        repeat (200) @(negedge core_clk);
        button_n = 1'b1;
        repeat (2) @(negedge core_clk);
        power_on();
        chk("on time", n >= 33 * CM && n <= 35 * CM + 8);
        chk_pins();
    endtask : t_power_on
    task automatic t_kill_off();
        repeat (RUNW) @(negedge core_clk);
        kill_req = 1'b1;
        wait_en(1'b0, 1500);
        chk("kill", n < 1500);
        chk_pins();
        kill_req = 1'b0;
        // press well inside lockout and hold past its end: must stay ignored
        repeat (200 * CM) @(negedge core_clk);
        button_n = 1'b0;
        repeat (60 * CM) @(negedge core_clk);
        chk("lockout", en_pin.en_out === 1'b0);
        button_n = 1'b1;
        repeat (IDLE) @(negedge core_clk);
    endtask : t_kill_off
    task automatic t_shutdown(input logic [1:0] m);
        mode = m;
        cfg.turn_off_extend = 16'h0003;
        power_on();
        // press again in blanking, hold past its end: ignored, then release debounced
        repeat (2) @(negedge core_clk);
        button_n = 1'b0;
        repeat (RUNW + 40 * CM) @(negedge core_clk);
        chk("held press", shutdown_req_n === 1'b1 && en_pin.en_out === 1'b1);
        button_n = 1'b1;
        repeat ((DEBOUNCE_MS + 4) * CM) @(negedge core_clk);
        button_n = 1'b0;
        for (n = 0; n < 500 && shutdown_req_n !== 1'b0; n++) @(negedge core_clk);
        chk("off time", n >= 34 * CM && n <= 36 * CM + 8);
        chk_pins();
        button_n = 1'b1;
        wait_en(1'b0, 1026 * CM);
        if (m == 2'h0) chk("ack", n > 200 && n < 400 && shutdown_req_n === 1'b1);
        else chk("timeout", n >= 1023 * CM && n <= 1025 * CM + 8);
        repeat (IDLE) @(negedge core_clk);
    endtask : t_shutdown
    task automatic t_abort();
        mode = 2'h1;
        power_on();
        wait_en(1'b0, 514 * CM);
        chk("abort", n >= 511 * CM && n <= 513 * CM + 8);
        chk_pins();
    endtask : t_abort
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    // hang guard, about twice the expected run
    initial begin
        #2_000_000;
        fails++;
        end_of_test();
    end
    // main sequence
    initial begin
        repeat (4) @(negedge core_clk);
        rst = 1'b0;
        repeat (2) @(negedge core_clk);
        t_power_on();
        t_kill_off();
        t_shutdown(2'h0);
        t_shutdown(2'h2);
        t_abort();
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
